// ===== rtl/ccs_pkg.sv
package ccs_pkg;

    // Register map, byte offsets on the plain register port
    localparam logic [3:0] CCS_OFF_CTRL = 4'h0;
    localparam logic [3:0] CCS_OFF_STAT = 4'h4;
    localparam logic [3:0] CCS_OFF_FUSE = 4'h8;

    // Control register fields
    localparam int CCS_CTRL_MODE_LSB  = 0;
    localparam int CCS_CTRL_SLEEP_BIT = 3;
    localparam int CCS_CTRL_ASRC_BIT  = 4;
    localparam int CCS_CTRL_CONV_BIT  = 5;
    localparam logic [7:0] CCS_CTRL_RESET = 8'h20;

    // Fuse fields as seen through the raw fuse word
    localparam int CCS_FUSE_CKSEL_LSB = 0;
    localparam int CCS_FUSE_SUT_LSB   = 4;
    localparam int CCS_FUSE_DIV8_BIT  = 6;

    // Start-up figures in cycles of the timed oscillator
    localparam logic [15:0] CCS_RST_EXTRA_CK = 16'h000E;
    localparam logic [15:0] CCS_WAKE_258CK   = 16'h0102;
    localparam logic [15:0] CCS_WAKE_1KCK    = 16'h0400;
    localparam int          CCS_WAKE_16KCK   = 16384;
    localparam logic [13:0] CCS_TOUT_NONE    = 14'h0000;
    localparam logic [13:0] CCS_TOUT_4K      = 14'h1000;
    localparam int          CCS_TOUT_8K      = 8192;
    localparam logic [2:0]  CCS_DIV8_LAST    = 3'h7;

    // Raw fuse word: a one is unprogrammed, a zero programmed
    typedef struct packed {
        logic       div8;
        logic [1:0] sut;
        logic [3:0] cksel;
    } ccs_fuse_t;

    localparam ccs_fuse_t CCS_FUSE_DEFAULT = '{div8: 1'b0, sut: 2'b10,
                                               cksel: 4'b0010};

    typedef enum logic [2:0] {
        CCS_SRC_LP    = 3'h0,
        CCS_SRC_FS    = 3'h1,
        CCS_SRC_LF    = 3'h2,
        CCS_SRC_RC128 = 3'h3,
        CCS_SRC_RC    = 3'h4,
        CCS_SRC_EXT   = 3'h5,
        CCS_SRC_RSVD  = 3'h6
    } ccs_src_t;

    typedef enum logic [2:0] {
        CCS_SLP_IDLE  = 3'h0,
        CCS_SLP_CONV  = 3'h1,
        CCS_SLP_PDOWN = 3'h2,
        CCS_SLP_PSAVE = 3'h3
    } ccs_sleep_t;

    typedef enum logic [2:0] {
        CCS_ST_CAPT  = 3'b000,
        CCS_ST_TOUT  = 3'b001,
        CCS_ST_RIPL  = 3'b011,
        CCS_ST_RUN   = 3'b010,
        CCS_ST_SLEEP = 3'b110
    } ccs_state_t;

    typedef struct packed {
        logic core;
        logic periph;
        logic flash;
        logic async_tmr;
        logic conv;
    } ccs_clk_en_t;

endpackage : ccs_pkg

// ===== rtl/ccs_clock_ctrl.sv
`timescale 1ns/1ps

// Notes on behaviour
// - Core clock stops all core execution
// - Peripheral clock; async interrupts still detected
// - Program memory clock follows core clock
// - Async timer clock runs through sleep; the code stops it in power-down
// - Converter clock survives core/peripheral stop
// - Source fuse codes pick crystal types
// - 0011 128k, 0010 RC, 0000 external
// - Fuse bit zero means programmed
// - Default: RC, divide-by-eight, start-up 10
// - Extra time-out after reset release
// - Time-out 0, 4096 or 8192 watchdog cycles
// - Ripple counter holds reset until count
// - Reset: both delays; power-down/save wake: start-up only, other wakes none
// - Low power crystal frequency range bits
// - Divide-by-eight fuse divides system clock
// - Codes 0/00, 0/01: 258CK wake
// - Codes 0/10, 0/11, 1/00: 1KCK wake
// - Codes 1/01, 1/10, 1/11: 16KCK wake
// - Sleep modes stop unused domain clocks
module ccs_clock_ctrl
    import ccs_pkg::*;
#(
    parameter int TOUT_LONG_CYCLES = CCS_TOUT_8K,
    parameter int WAKE_LONG_CYCLES = CCS_WAKE_16KCK
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Fuse word, raw, sampled once after reset
    input  wire ccs_fuse_t   fuse_raw,
    // Oscillator ticks, one-cycle pulses
    input  wire logic        osc_tick,
    input  wire logic        wdt_tick,
    input  wire logic        ext_tmr_tick,
    input  wire logic        xtal32_tick,
    // Wake sources
    input  wire logic        async_irq,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Clock domain outputs
    output ccs_clk_en_t      clk_en,
    output logic             sys_tick,
    output logic             async_timer_clock,
    output logic             async_wake,
    output logic             int_rst
);

    localparam logic [13:0] TOUT_LONG = 14'(TOUT_LONG_CYCLES);
    localparam logic [15:0] WAKE_LONG = 16'(WAKE_LONG_CYCLES);

    ccs_fuse_t   fuse_q;
    ccs_state_t  state_q;
    ccs_src_t    src;
    ccs_clk_en_t en_d;
    ccs_clk_en_t clk_en_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  rdata_q;
    logic [13:0] tout_cnt_q;
    logic [15:0] ripl_cnt_q;
    logic [13:0] tout_len;
    logic [15:0] wake_len;
    logic [15:0] ripl_len;
    logic        from_wake_q;
    logic [2:0]  div_q;
    logic        sys_tick_q;
    logic        atmr_q;
    logic        awake_q;
    logic        int_rst_q;
    logic        div8_on;
    logic [1:0]  lp_range;
    logic        sleep_req;
    ccs_sleep_t  mode;

    // Fuse decode
    // fuse active low
    assign div8_on   = ~fuse_q.div8;
    assign lp_range  = fuse_q.cksel[2:1];
    assign mode      = ccs_sleep_t'(ctrl_q[CCS_CTRL_MODE_LSB +: 3]);
    assign sleep_req = reg_wr && (reg_addr == CCS_OFF_CTRL)
                       && reg_wdata[CCS_CTRL_SLEEP_BIT];

    // Reserved code still starts; status shows it to software
    always_comb begin
        if (fuse_q.cksel[3]) begin
            src = CCS_SRC_LP;
        end else begin
            case (fuse_q.cksel[2:0])
                3'h7, 3'h6: src = CCS_SRC_FS;
                3'h5, 3'h4: src = CCS_SRC_LF;
                3'h3:       src = CCS_SRC_RC128;
                3'h2:       src = CCS_SRC_RC;
                3'h0:       src = CCS_SRC_EXT;
                default:    src = CCS_SRC_RSVD;
            endcase
        end
    end

    // Start-up lengths; one code table times every source, but cksel 00xx sources take their own time-out
    always_comb begin
        case ({fuse_q.cksel[0], fuse_q.sut})
            3'b000: begin
                wake_len = CCS_WAKE_258CK;
                tout_len = CCS_TOUT_4K;
            end
            3'b001: begin
                wake_len = CCS_WAKE_258CK;
                tout_len = TOUT_LONG;
            end
            3'b010: begin
                wake_len = CCS_WAKE_1KCK;
                tout_len = CCS_TOUT_NONE;
            end
            3'b011: begin
                wake_len = CCS_WAKE_1KCK;
                tout_len = CCS_TOUT_4K;
            end
            3'b100: begin
                wake_len = CCS_WAKE_1KCK;
                tout_len = TOUT_LONG;
            end
            3'b101: begin
                wake_len = WAKE_LONG;
                tout_len = CCS_TOUT_NONE;
            end
            3'b110: begin
                wake_len = WAKE_LONG;
                tout_len = CCS_TOUT_4K;
            end
            default: begin
                wake_len = WAKE_LONG;
                tout_len = TOUT_LONG;
            end
        endcase
        // RC, 128k and external sources (cksel 00xx): start-up bits alone
        // pick the time-out, so the shipped 10 gives the longest one
        if (fuse_q.cksel[3:2] == 2'b00) begin
            case (fuse_q.sut)
                2'b00:   tout_len = CCS_TOUT_NONE;
                2'b01:   tout_len = CCS_TOUT_4K;
                default: tout_len = TOUT_LONG;
            endcase
        end
    end

    // reset adds 14CK, wake does not
    assign ripl_len = from_wake_q ? wake_len : wake_len + CCS_RST_EXTRA_CK;

    // Fuses are caught after reset release, never under it
    // So a programmer may still change them while reset is held
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fuse_q <= CCS_FUSE_DEFAULT;
        end else if (state_q == CCS_ST_CAPT) begin
            fuse_q <= fuse_raw;
        end
    end

    // Start-up and sleep sequencer
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q     <= CCS_ST_CAPT;
            from_wake_q <= 1'b0;
        end else begin
            case (state_q)
                CCS_ST_CAPT: begin
                    state_q     <= CCS_ST_TOUT;
                    from_wake_q <= 1'b0;
                end
                CCS_ST_TOUT: begin
                    if (tout_cnt_q >= tout_len) begin
                        state_q <= CCS_ST_RIPL;
                    end
                end
                CCS_ST_RIPL: begin
                    if (ripl_cnt_q >= ripl_len) begin
                        state_q <= CCS_ST_RUN;
                    end
                end
                CCS_ST_RUN: begin
                    if (sleep_req) begin
                        state_q <= CCS_ST_SLEEP;
                    end
                end
                CCS_ST_SLEEP: begin
                    if (async_irq) begin
                        if (mode == CCS_SLP_PDOWN
                            || mode == CCS_SLP_PSAVE) begin
                            state_q     <= CCS_ST_RIPL;
                            from_wake_q <= 1'b1;
                        end else begin
                            state_q <= CCS_ST_RUN;
                        end
                    end
                end
                default: begin
                    state_q <= CCS_ST_CAPT;
                end
            endcase
        end
    end

    // Time-out counter on watchdog ticks; saturates at its length
    // Cleared outside TOUT so a re-entry always starts from zero
    always_ff @(posedge core_clk) begin
        if (sys_rst || state_q != CCS_ST_TOUT) begin
            tout_cnt_q <= 14'h0000;
        end else if (wdt_tick && tout_cnt_q < tout_len) begin
            tout_cnt_q <= tout_cnt_q + 14'h0001;
        end
    end

    // Ripple counter on selected-oscillator ticks; saturates too
    always_ff @(posedge core_clk) begin
        if (sys_rst || state_q != CCS_ST_RIPL) begin
            ripl_cnt_q <= 16'h0000;
        end else if (osc_tick && ripl_cnt_q < ripl_len) begin
            ripl_cnt_q <= ripl_cnt_q + 16'h0001;
        end
    end

    // Registered so the internal reset never glitches on decode
    // A wake from deep sleep keeps it low; only reset raises it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            int_rst_q <= 1'b1;
        end else begin
            int_rst_q <= (state_q == CCS_ST_CAPT) || (state_q == CCS_ST_TOUT)
                         || (state_q == CCS_ST_RIPL && !from_wake_q)
                         || (state_q == CCS_ST_RIPL && ripl_cnt_q < ripl_len
                             && !from_wake_q);
        end
    end

    // Divider runs when bypassed too, so its phase never resets
    // divide by eight
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_q      <= 3'h0;
            sys_tick_q <= 1'b0;
        end else begin
            sys_tick_q <= 1'b0;
            if (osc_tick) begin
                div_q <= div_q + 3'h1;
                if (!div8_on || div_q == CCS_DIV8_LAST) begin
                    sys_tick_q <= 1'b1;
                end
            end
        end
    end

    // Domain enables per sleep mode
    // Power-down and the unnamed mode codes 4 to 7 are the only modes that also stop the timer domain
    always_comb begin
        en_d = '0;
        // async timer gated by sleep in power-down and in the unnamed mode codes 4 to 7
        en_d.async_tmr = 1'b1;
        if (state_q == CCS_ST_RUN) begin
            en_d.core   = 1'b1;
            en_d.flash  = 1'b1;
            en_d.periph = 1'b1;
            en_d.conv   = ctrl_q[CCS_CTRL_CONV_BIT];
        end else if (state_q == CCS_ST_SLEEP) begin
            case (mode)
                CCS_SLP_IDLE: begin
                    en_d.periph = 1'b1;
                    en_d.conv   = ctrl_q[CCS_CTRL_CONV_BIT];
                end
                CCS_SLP_CONV: begin
                    en_d.conv = 1'b1;
                end
                CCS_SLP_PSAVE: begin
                    en_d.async_tmr = 1'b1;
                end
                default: begin
                    en_d.async_tmr = 1'b0;
                end
            endcase
        end
    end

    // An enable may wait a cycle for a quiet slot; no runt pulses
    // gates change only between clock pulses
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clk_en_q <= '0;
        end else if (!osc_tick) begin
            clk_en_q <= en_d;
        end
    end

    // Uses the live enable so no pulse leaks past the gate
    // timer tick source select
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            atmr_q <= 1'b0;
        end else begin
            atmr_q <= en_d.async_tmr && (ctrl_q[CCS_CTRL_ASRC_BIT]
                      ? xtal32_tick : ext_tmr_tick);
        end
    end

    // Never gated: it must work with every domain stopped
    // async interrupt seen while gated
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            awake_q <= 1'b0;
        end else begin
            awake_q <= async_irq;
        end
    end

    // Register port
    // Unmapped writes fall through and are dropped
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_q <= CCS_CTRL_RESET;
        end else if (reg_wr && reg_addr == CCS_OFF_CTRL) begin
            // Sleep request bit is a strobe, not stored
            ctrl_q <= reg_wdata & ~(8'h01 << CCS_CTRL_SLEEP_BIT);
        end
    end

    // Read data stand one cycle only, then return to zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                CCS_OFF_CTRL: rdata_q <= ctrl_q;
                CCS_OFF_STAT: rdata_q <= {int_rst_q, div8_on, lp_range,
                                          1'b0, src};
                CCS_OFF_FUSE: rdata_q <= {1'b0, fuse_q};
                default:      rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata         = rdata_q;
    assign clk_en            = clk_en_q;
    assign sys_tick          = sys_tick_q;
    assign async_timer_clock = atmr_q;
    assign async_wake        = awake_q;
    assign int_rst           = int_rst_q;

endmodule : ccs_clock_ctrl

// ===== dv/ccs_clock_ctrl_checker.sv
`timescale 1ns/1ps
module ccs_clock_ctrl_checker
    import ccs_pkg::*;
#(
    parameter int TOUT_LONG_CYCLES = CCS_TOUT_8K,
    parameter int WAKE_LONG_CYCLES = CCS_WAKE_16KCK
) (
    // Block inputs
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire ccs_fuse_t   fuse_raw,
    input wire logic        osc_tick,
    input wire logic        wdt_tick,
    input wire logic        ext_tmr_tick,
    input wire logic        xtal32_tick,
    input wire logic        async_irq,
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    // Block outputs
    input wire logic [7:0]  reg_rdata,
    input wire ccs_clk_en_t clk_en,
    input wire logic        sys_tick,
    input wire logic        async_timer_clock,
    input wire logic        async_wake,
    input wire logic        int_rst
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    chk_reset_hold: assert property (
        $fell(sys_rst) |-> int_rst && clk_en == '0)
        else $error("internal reset not held at release");
    chk_ripple_min: assert property (
        $fell(sys_rst) |-> int_rst [*8] ##1 int_rst [*8])
        else $error("internal reset released too early");
    chk_no_reassert: assert property (
        !int_rst |=> !int_rst)
        else $error("internal reset came back without reset");
    chk_core_after: assert property (
        $rose(clk_en.core) |-> ##[0:2] !int_rst)
        else $error("core clock runs under internal reset");
    chk_flash_core: assert property (
        clk_en.flash == clk_en.core)
        else $error("program memory clock apart from core clock");
    chk_gate_clean: assert property (
        !$past(sys_rst) && $changed(clk_en) |-> !$past(osc_tick))
        else $error("clock gate switched on an oscillator tick");
    chk_wake_copy: assert property (
        !$past(sys_rst) |-> async_wake == $past(async_irq))
        else $error("wake output not a copy of the interrupt");
    chk_async_src: assert property (
        async_timer_clock |-> $past(ext_tmr_tick || xtal32_tick))
        else $error("timer clock pulse without a source tick");
    chk_tick_src: assert property (
        sys_tick |-> $past(osc_tick))
        else $error("system tick without an oscillator tick");

    cover property ($fell(int_rst));
    cover property (async_timer_clock && !clk_en.core);
    cover property ($rose(clk_en.core) && !int_rst && $past(!int_rst));
endmodule : ccs_clock_ctrl_checker

bind ccs_clock_ctrl ccs_clock_ctrl_checker #(
    .TOUT_LONG_CYCLES(TOUT_LONG_CYCLES),
    .WAKE_LONG_CYCLES(WAKE_LONG_CYCLES)
) ccs_clock_ctrl_checker_inst (.*);

// ===== dv/ccs_osc_model.sv
`timescale 1ns/1ps
module ccs_osc_model (
    // Clock and pacing
    input  wire logic core_clk,
    input  wire logic slow,
    // Oscillator ticks
    output logic      osc_tick,
    output logic      wdt_tick,
    output logic      ext_tmr_tick,
    output logic      xtal32_tick
);
    logic [3:0] cnt_q = 4'h0;

    always_ff @(posedge core_clk) begin
        cnt_q <= cnt_q + 4'h1;
    end
    // behaves as resonator
    // Never ticks every cycle, so gates always get a quiet cycle
    assign osc_tick     = cnt_q[0] & (~slow | cnt_q[1]);
    assign wdt_tick     = 1'b1;
    assign ext_tmr_tick = (cnt_q[2:0] == 3'h0);
    assign xtal32_tick  = (cnt_q[1:0] == 2'h2);
endmodule : ccs_osc_model

// ===== dv/ccs_clock_ctrl_bench.sv
`timescale 1ns/1ps
module ccs_clock_ctrl_bench import ccs_pkg::*;;
    localparam int TL = 16;
    localparam int WL = 32;
    logic        core_clk  = 1'b0;
    logic        sys_rst   = 1'b1;
    ccs_fuse_t   fuse_raw  = CCS_FUSE_DEFAULT;
    logic        slow      = 1'b0;
    logic        async_irq = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [7:0]  reg_rdata;
    ccs_clk_en_t clk_en;
    logic        osc_tick, wdt_tick, ext_tmr_tick, xtal32_tick;
    logic        sys_tick, async_timer_clock, async_wake, int_rst;
    int          err_total = 0;
    int          checks_done = 0;

    ccs_osc_model ccs_osc_model_inst (
        .core_clk          (core_clk),
        .slow              (slow),
        .osc_tick          (osc_tick),
        .wdt_tick          (wdt_tick),
        .ext_tmr_tick      (ext_tmr_tick),
        .xtal32_tick       (xtal32_tick)
    );
    ccs_clock_ctrl #(.TOUT_LONG_CYCLES(TL), .WAKE_LONG_CYCLES(WL))
        ccs_clock_ctrl_inst (
        .core_clk          (core_clk),
        .sys_rst           (sys_rst),
        .fuse_raw          (fuse_raw),
        .osc_tick          (osc_tick),
        .wdt_tick          (wdt_tick),
        .ext_tmr_tick      (ext_tmr_tick),
        .xtal32_tick       (xtal32_tick),
        .async_irq         (async_irq),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_rdata         (reg_rdata),
        .clk_en            (clk_en),
        .sys_tick          (sys_tick),
        .async_timer_clock (async_timer_clock),
        .async_wake        (async_wake),
        .int_rst           (int_rst)
    );

    initial forever #5 core_clk = ~core_clk;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    function automatic logic [7:0] stat_of(input ccs_fuse_t f);
        ccs_src_t   s;
        logic [3:0] c;
        c = f.cksel;
        if (c[3]) s = CCS_SRC_LP;
        else if (c[2:1] == 2'b11) s = CCS_SRC_FS;
        else if (c[2:1] == 2'b10) s = CCS_SRC_LF;
        else if (c == 4'h3) s = CCS_SRC_RC128;
        else if (c == 4'h2) s = CCS_SRC_RC;
        else if (c == 4'h0) s = CCS_SRC_EXT;
        else s = CCS_SRC_RSVD;
        return {1'b0, ~f.div8, c[2:1], 1'b0, s};
    endfunction : stat_of

    // Reset, time the release, then read status back
    task automatic run_startup(input ccs_fuse_t f);
        logic [2:0] k;
        logic [7:0] d;
        int         n;
        int         e;
        int         t;
        k = {f.cksel[0], f.sut};
        t = (k == 3'h2 || k == 3'h5) ? 0 : (k % 3 == 0) ? 4096 : TL;
        // Internal and external sources time out on the start-up bits alone
        if (f.cksel[3:2] == 2'b00)
            t = (f.sut == 2'b00) ? 0 : (f.sut == 2'b01) ? 4096 : TL;
        e = 1 + t + 2 * (((k < 3'h2) ? 258 : (k < 3'h5) ? 1024 : WL) + 14);
        n = 0;
        @(posedge core_clk);
        fuse_raw <= f;
        sys_rst  <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (int_rst !== 1'b0 && n < 20000);
        chk(16'(n >= e - 3 && n <= e + 6), 16'h1);
        repeat (4) @(posedge core_clk);
        #1;
        chk({11'h0, clk_en}, 16'h1F);
        rd(CCS_OFF_STAT, d);
        chk({8'h0, d}, {8'h0, stat_of(f)});
        rd(CCS_OFF_FUSE, d);
        chk({8'h0, d}, {9'h0, f});
        n = 0;
        repeat (64) begin
            @(posedge core_clk);
            #1;
            if (sys_tick === 1'b1) n++;
        end
        chk(16'(n), f.div8 ? 16'h20 : 16'h4);
    endtask : run_startup

    task automatic test_timing;
        for (int k = 0; k < 8; k++)
            run_startup('{div8: 1'b1, sut: k[1:0], cksel: {3'b111, k[2]}});
        $display("timing test done");
    endtask : test_timing

    task automatic test_sources;
        for (int c = 0; c < 16; c++)
            run_startup('{div8: c[0], sut: 2'b01, cksel: c[3:0]});
        $display("source test done");
    endtask : test_sources

    task automatic test_sleep;
        logic [7:0] d;
        int         n;
        logic       bad;
        run_startup(CCS_FUSE_DEFAULT);
        rd(CCS_OFF_CTRL, d);
        chk({8'h0, d}, {8'h0, CCS_CTRL_RESET});
        // Awake with the external timer source selected
        n = 0;
        repeat (32) begin
            @(posedge core_clk);
            #1;
            if (async_timer_clock === 1'b1) n++;
        end
        chk(16'(n), 16'h4);
        for (int m = 0; m < 4; m++) begin
            wr(CCS_OFF_CTRL, 8'h38 | 8'(m));
            repeat (6) @(posedge core_clk);
            #1;
            chk({15'h0, clk_en.core}, 16'h0);
            chk({15'h0, clk_en.async_tmr}, 16'(m != 2));
            if (m == 1) chk({15'h0, clk_en.conv}, 16'h1);
            n = 0;
            repeat (32) begin
                @(posedge core_clk);
                #1;
                if (async_timer_clock === 1'b1) n++;
            end
            chk(16'(n), (m == 2) ? 16'h0 : 16'h8);
            // Slow oscillator on deep sleep stretches the ripple count
            @(posedge core_clk);
            slow      <= (m > 1);
            async_irq <= 1'b1;
            n   = 0;
            bad = 1'b0;
            do begin
                @(posedge core_clk);
                #1;
                n++;
                if (int_rst !== 1'b0) bad = 1'b1;
            end while (clk_en.core !== 1'b1 && n < 8000);
            chk({15'h0, bad}, 16'h0);
            if (m > 1)
                chk(16'(n >= 4090 && n <= 4110), 16'h1);
            else
                chk(16'(n <= 6), 16'h1);
            chk({15'h0, async_wake}, 16'h1);
            @(posedge core_clk);
            async_irq <= 1'b0;
            slow      <= 1'b0;
            @(posedge core_clk);
            #1;
            chk({15'h0, async_wake}, 16'h0);
        end
        rd(CCS_OFF_CTRL, d);
        chk({8'h0, d}, 16'h33);
        rd(4'hC, d);
        chk({8'h0, d}, 16'h0);
        wr(CCS_OFF_STAT, 8'hFF);
        rd(CCS_OFF_STAT, d);
        chk({8'h0, d}, {8'h0, stat_of(CCS_FUSE_DEFAULT)});
        $display("sleep test done");
    endtask : test_sleep

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    initial begin
        repeat (80000) @(posedge core_clk);
        err_total++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        test_timing();
        test_sources();
        test_sleep();
        conclude();
    end
endmodule : ccs_clock_ctrl_bench
